//--- opv_pkg.sv
package opv_pkg;

  // Clock and oscillator timing
  localparam int CLK_PERIOD_PS = 25000;
  localparam int OSC_SLOW_PS   = 250000;
  localparam int OSC_FAST_PS   = 166667;
  localparam int US_PS         = 1000000;
  localparam int SETUP_OSC     = 48;
  localparam int PULSE_US      = 100;
  localparam int GAP_US        = 10;
  localparam int VPP_SETUP_US  = 10;
  localparam int VPP_HOLD_US   = 10;

  // Least times round up, longest times round down
  localparam int SETUP_CYC =
    (SETUP_OSC * OSC_SLOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int VALID_MAX_CYC = SETUP_OSC * OSC_FAST_PS / CLK_PERIOD_PS;
  localparam int PULSE_CYC = PULSE_US * US_PS / CLK_PERIOD_PS;
  localparam int GAP_CYC =
    (GAP_US * US_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int VPP_SETUP_CYC =
    (VPP_SETUP_US * US_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int VPP_HOLD_CYC =
    (VPP_HOLD_US * US_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TMR_W = 13;

  // Strobe pulse counts
  localparam int PULSES_CODE = 5;
  localparam int PULSES_LONG = 25;
  localparam int PCNT_W      = 5;

  // Widths and sizes
  localparam int DATA_W         = 8;
  localparam int LO_W           = 8;
  localparam int HI_W           = 6;
  localparam int ADDR_W         = 14;
  localparam int CTRL_W         = 5;
  localparam int ENC_DEPTH      = 64;
  localparam int ENC_IDX_W      = 6;
  localparam int CODE_DEPTH_DEF = 8192;

  localparam logic [DATA_W-1:0] ERASED    = 8'hff;
  localparam logic [ADDR_W-1:0] SIG_ADDR0 = 14'h0030;
  localparam logic [ADDR_W-1:0] SIG_ADDR1 = 14'h0031;
  localparam logic [ADDR_W-1:0] SIG_ADDR2 = 14'h0060;

  // Control lines {p2_6, p2_7, p3_3, p3_6, p3_7}
  localparam logic [CTRL_W-1:0] CTRL_PROG_CODE = 5'h0f;
  localparam logic [CTRL_W-1:0] CTRL_VERIFY    = 5'h03;
  localparam logic [CTRL_W-1:0] CTRL_PROG_ENC  = 5'h0d;
  localparam logic [CTRL_W-1:0] CTRL_LOCK1     = 5'h1f;
  localparam logic [CTRL_W-1:0] CTRL_LOCK2     = 5'h1c;
  localparam logic [CTRL_W-1:0] CTRL_LOCK3     = 5'h16;
  localparam logic [CTRL_W-1:0] CTRL_SIG       = 5'h00;

  typedef enum {
    MODE_NONE, MODE_PROG_CODE, MODE_VERIFY, MODE_PROG_ENC,
    MODE_LOCK1, MODE_LOCK2, MODE_LOCK3, MODE_SIG
  } opv_mode_e;

  function automatic opv_mode_e opv_decode(input logic [CTRL_W-1:0] c);
    case (c)
      CTRL_PROG_CODE: opv_decode = MODE_PROG_CODE;
      CTRL_VERIFY:    opv_decode = MODE_VERIFY;
      CTRL_PROG_ENC:  opv_decode = MODE_PROG_ENC;
      CTRL_LOCK1:     opv_decode = MODE_LOCK1;
      CTRL_LOCK2:     opv_decode = MODE_LOCK2;
      CTRL_LOCK3:     opv_decode = MODE_LOCK3;
      CTRL_SIG:       opv_decode = MODE_SIG;
      default:        opv_decode = MODE_NONE;
    endcase
  endfunction

  function automatic logic [CTRL_W-1:0] opv_encode(input opv_mode_e m);
    case (m)
      MODE_PROG_CODE: opv_encode = CTRL_PROG_CODE;
      MODE_PROG_ENC:  opv_encode = CTRL_PROG_ENC;
      MODE_LOCK1:     opv_encode = CTRL_LOCK1;
      MODE_LOCK2:     opv_encode = CTRL_LOCK2;
      MODE_LOCK3:     opv_encode = CTRL_LOCK3;
      MODE_SIG:       opv_encode = CTRL_SIG;
      default:        opv_encode = CTRL_VERIFY;
    endcase
  endfunction

endpackage

//--- opv_link_if.sv
`timescale 1ns/1ps
interface opv_link_if;
  import opv_pkg::*;
  logic [LO_W-1:0]   p1_addr_lo;
  logic [HI_W-1:0]   p2_addr_hi;
  logic [CTRL_W-1:0] ctrl;
  logic              rst_pin;
  logic              psen_n;
  logic              program_pulse_strobe_n;
  logic              program_voltage_enable;
  logic [DATA_W-1:0] host_data_out;
  logic              host_data_oe;
  logic [DATA_W-1:0] dev_data_out;
  logic              dev_data_oe;
  logic [DATA_W-1:0] data;

  // Pulled high when nobody drives
  assign data = dev_data_oe ? dev_data_out :
                host_data_oe ? host_data_out : ERASED;

  modport host (
    output p1_addr_lo, p2_addr_hi, ctrl, rst_pin, psen_n,
    output program_pulse_strobe_n, program_voltage_enable,
    output host_data_out, host_data_oe,
    input  data
  );

  modport dev (
    input  p1_addr_lo, p2_addr_hi, ctrl, rst_pin, psen_n,
    input  program_pulse_strobe_n, program_voltage_enable,
    output dev_data_out, dev_data_oe,
    input  data
  );
endinterface

//--- opv_host.sv
`timescale 1ns/1ps
module opv_host
  import opv_pkg::*;
(
  input  logic              clk,
  input  logic              rst,
  opv_link_if.host          link,
  input  logic              start,
  input  opv_mode_e         cmd_mode,
  input  logic [ADDR_W-1:0] cmd_addr,
  input  logic [DATA_W-1:0] cmd_data,
  output logic              busy,
  output logic              done,
  output logic [DATA_W-1:0] rd_data
);

  typedef enum {
    H_IDLE, H_SETUP, H_VPP_UP, H_PULSE, H_GAP, H_VPP_DN, H_HOLD, H_READ
  } opv_hstate_e;

  opv_hstate_e       state_r;
  logic [TMR_W-1:0]  tmr_r;
  logic [PCNT_W-1:0] pcnt_r;
  logic [PCNT_W-1:0] need_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] data_r;
  logic [CTRL_W-1:0] ctrl_r;
  logic              sel_r;
  logic              oe_r;
  logic              strobe_n_r;
  logic              vpp_r;
  logic              done_r;
  logic              tdone;

  assign tdone = (tmr_r == '0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r    <= H_IDLE;
      tmr_r      <= '0;
      pcnt_r     <= '0;
      need_r     <= '0;
      addr_r     <= '0;
      data_r     <= '0;
      ctrl_r     <= CTRL_VERIFY;
      sel_r      <= 1'b0;
      oe_r       <= 1'b0;
      strobe_n_r <= 1'b1;
      vpp_r      <= 1'b0;
      done_r     <= 1'b0;
      rd_data    <= '0;
    end else begin
      done_r <= 1'b0;
      if (!tdone) begin
        tmr_r <= tmr_r - 1'b1;
      end
      case (state_r)
        H_IDLE: begin
          if (start) begin
            addr_r <= cmd_addr;
            data_r <= cmd_data;
            ctrl_r <= opv_encode(cmd_mode);
            sel_r  <= 1'b1;
            pcnt_r <= '0;
            need_r <= (cmd_mode == MODE_PROG_CODE) ?
                      PCNT_W'(PULSES_CODE) : PCNT_W'(PULSES_LONG);
            tmr_r  <= TMR_W'(SETUP_CYC - 1);
            if (cmd_mode == MODE_VERIFY || cmd_mode == MODE_SIG) begin
              state_r <= H_READ;
            end else begin
              oe_r    <= 1'b1;
              state_r <= H_SETUP;
            end
          end
        end
        H_SETUP: if (tdone) begin
          vpp_r   <= 1'b1;
          tmr_r   <= TMR_W'(VPP_SETUP_CYC - 1);
          state_r <= H_VPP_UP;
        end
        H_VPP_UP, H_GAP: if (tdone) begin
          strobe_n_r <= 1'b0;
          tmr_r      <= TMR_W'(PULSE_CYC - 1);
          state_r    <= H_PULSE;
        end
        H_PULSE: if (tdone) begin
          strobe_n_r <= 1'b1;
          pcnt_r     <= pcnt_r + 1'b1;
          if (pcnt_r + 1'b1 == need_r) begin
            tmr_r   <= TMR_W'(VPP_HOLD_CYC - 1);
            state_r <= H_VPP_DN;
          end else begin
            tmr_r   <= TMR_W'(GAP_CYC - 1);
            state_r <= H_GAP;
          end
        end
        H_VPP_DN: if (tdone) begin
          vpp_r   <= 1'b0;
          tmr_r   <= TMR_W'(SETUP_CYC - 1);
          state_r <= H_HOLD;
        end
        H_HOLD: if (tdone) begin
          oe_r    <= 1'b0;
          sel_r   <= 1'b0;
          done_r  <= 1'b1;
          state_r <= H_IDLE;
        end
        H_READ: if (tdone) begin
          rd_data <= link.data;
          sel_r   <= 1'b0;
          done_r  <= 1'b1;
          state_r <= H_IDLE;
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  assign link.p1_addr_lo             = addr_r[LO_W-1:0];
  assign link.p2_addr_hi             = addr_r[ADDR_W-1:LO_W];
  assign link.ctrl                   = ctrl_r;
  assign link.rst_pin                = 1'b1;
  assign link.psen_n                 = ~sel_r;
  assign link.program_pulse_strobe_n = strobe_n_r;
  assign link.program_voltage_enable = vpp_r;
  assign link.host_data_out          = data_r;
  assign link.host_data_oe           = oe_r;
  assign busy                        = (state_r != H_IDLE);
  assign done                        = done_r;

endmodule // opv_host

//--- opv_device.sv
// Functional notes
// - Programmer sets address, data, controls, then voltage
// - Five pulses code, twenty-five encryption or lock
// - Programmer repeats sequence per location
// - Verify per byte or block, full pass
// - Lock bits never read back directly
// - Sixty-four byte encryption array, erased all ones
// - Verify returns code XNOR selected encryption byte
// - Unused code should hold varied non-FF values
// - No locks: verify still scrambled
// - Lock one: table reads, access latch, programming
// - Lock two adds verify disable
// - Lock three adds external execution refusal
// - Only cumulative lock order accepted
// - Mask version: encryption only with lock
// - Erase clears code, encryption and locks
// - Signature bytes at 30H, 31H, 60H
// - Address and data stable around strobe
// - Strobe high at least ten microseconds
// - Verify data valid within 48 oscillator periods
// - Address on port one and port two low bits
`timescale 1ns/1ps
module opv_device
  import opv_pkg::*;
#(
  parameter int              CODE_DEPTH   = CODE_DEPTH_DEF,
  parameter bit              MASK_VERSION = 1'b0,
  // Signature values are arbitrary
  parameter logic [DATA_W-1:0] SIG_BYTE0  = 8'ha5,
  parameter logic [DATA_W-1:0] SIG_BYTE1  = 8'h3c,
  parameter logic [DATA_W-1:0] SIG_BYTE2  = 8'h0e
) (
  input  logic     clk,
  input  logic     rst,
  opv_link_if.dev  link,
  input  logic     erase_req,
  input  logic     external_access_select,
  output logic     busy,
  output logic     code_table_read_block,
  output logic     external_access_latched,
  output logic     program_block,
  output logic     verify_block,
  output logic     ext_exec_block
);

  localparam int IDX_W = $clog2(CODE_DEPTH);
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(CODE_DEPTH - 1);

  logic [DATA_W-1:0] code_mem [CODE_DEPTH];
  logic [DATA_W-1:0] enc_mem [ENC_DEPTH];

  logic [IDX_W-1:0]  sweep_r;
  logic              sweep_busy_r;
  logic [DATA_W-1:0] rd_r;
  logic [DATA_W-1:0] dout_r;
  logic              strobe_d_r;
  logic [PCNT_W-1:0] pcnt_r;
  logic [ADDR_W-1:0] last_addr_r;
  opv_mode_e         last_mode_r;
  logic              lock_level_one_bit_r;
  logic              lock_level_two_bit_r;
  logic              lock_level_three_bit_r;
  logic              enc_loaded_r;
  logic              access_latch_r;

  logic [ADDR_W-1:0]    addr;
  logic [IDX_W-1:0]     idx;
  logic [ENC_IDX_W-1:0] enc_idx;
  opv_mode_e            mode;
  logic                 prog_mode;
  logic                 same_loc;
  logic                 strobe_rise;
  logic [PCNT_W-1:0]    need;
  logic                 commit;
  logic [DATA_W-1:0]    enc_sel;

  assign addr    = {link.p2_addr_hi, link.p1_addr_lo};
  assign idx     = addr[IDX_W-1:0];
  assign enc_idx = addr[ENC_IDX_W-1:0];

  // Modes need reset pin high and enable low
  assign mode = (link.rst_pin && !link.psen_n) ?
                opv_decode(link.ctrl) : MODE_NONE;

  assign prog_mode = (mode == MODE_PROG_CODE) ||
                     (mode == MODE_PROG_ENC) ||
                     (mode == MODE_LOCK1) ||
                     (mode == MODE_LOCK2) ||
                     (mode == MODE_LOCK3);

  assign same_loc = (addr == last_addr_r) && (mode == last_mode_r);

  // Pulse is counted at its rising end
  assign strobe_rise = link.program_pulse_strobe_n && !strobe_d_r &&
                       link.program_voltage_enable && prog_mode &&
                       !sweep_busy_r;

  assign need = (mode == MODE_PROG_CODE) ?
                PCNT_W'(PULSES_CODE) : PCNT_W'(PULSES_LONG);

  assign commit = strobe_rise && same_loc && (pcnt_r + 1'b1 == need);

  // Erase sweep, also run as power-on state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sweep_r      <= '0;
      sweep_busy_r <= 1'b1;
    end else if (sweep_busy_r) begin
      sweep_r <= sweep_r + 1'b1;
      if (sweep_r == LAST_IDX) begin
        sweep_busy_r <= 1'b0;
      end
    end else if (erase_req) begin
      sweep_r      <= '0;
      sweep_busy_r <= 1'b1;
    end
  end

  // Pulse counter restarts on a new location
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strobe_d_r  <= 1'b1;
      pcnt_r      <= '0;
      last_addr_r <= '0;
      last_mode_r <= MODE_NONE;
    end else begin
      strobe_d_r  <= link.program_pulse_strobe_n;
      last_addr_r <= addr;
      last_mode_r <= mode;
      if (!same_loc || commit) begin
        pcnt_r <= '0;
      end else if (strobe_rise) begin
        pcnt_r <= pcnt_r + 1'b1;
      end
    end
  end

  // Cells only move from one to zero
  always_ff @(posedge clk) begin
    if (sweep_busy_r) begin
      code_mem[sweep_r] <= ERASED;
    end else if (commit && mode == MODE_PROG_CODE &&
                 !lock_level_one_bit_r) begin
      code_mem[idx] <= rd_r & link.data;
    end
  end

  always_ff @(posedge clk) begin
    rd_r <= code_mem[idx];
  end

  always_ff @(posedge clk) begin
    if (sweep_busy_r) begin
      enc_mem[sweep_r[ENC_IDX_W-1:0]] <= ERASED;
    end else if (commit && mode == MODE_PROG_ENC &&
                 !lock_level_one_bit_r) begin
      enc_mem[enc_idx] <= enc_mem[enc_idx] & link.data;
    end
  end

  // Lock bits reset as erased part
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_level_one_bit_r   <= 1'b0;
      lock_level_two_bit_r   <= 1'b0;
      lock_level_three_bit_r <= 1'b0;
      enc_loaded_r           <= 1'b0;
    end else if (sweep_busy_r) begin
      lock_level_one_bit_r   <= 1'b0;
      lock_level_two_bit_r   <= 1'b0;
      lock_level_three_bit_r <= 1'b0;
      enc_loaded_r           <= 1'b0;
    end else if (commit) begin
      if (mode == MODE_PROG_ENC && !lock_level_one_bit_r) begin
        enc_loaded_r <= 1'b1;
      end
      if (mode == MODE_LOCK1 && (!MASK_VERSION || enc_loaded_r)) begin
        lock_level_one_bit_r <= 1'b1;
      end
      if (mode == MODE_LOCK2 && lock_level_one_bit_r && !MASK_VERSION) begin
        lock_level_two_bit_r <= 1'b1;
      end
      if (mode == MODE_LOCK3 && lock_level_two_bit_r && !MASK_VERSION) begin
        lock_level_three_bit_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      access_latch_r <= 1'b0;
    end else if (!lock_level_one_bit_r || link.rst_pin) begin
      access_latch_r <= external_access_select;
    end
  end

  // Mask part scrambles only when locked
  assign enc_sel = (MASK_VERSION && !lock_level_one_bit_r) ?
                   ERASED : enc_mem[enc_idx];

  // Two cycles from address, far inside the limit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout_r <= ERASED;
    end else begin
      case (mode)
        MODE_VERIFY: begin
          if (lock_level_two_bit_r) begin
            dout_r <= ERASED;
          end else begin
            dout_r <= rd_r ~^ enc_sel;
          end
        end
        MODE_SIG: begin
          case (addr)
            SIG_ADDR0: dout_r <= SIG_BYTE0;
            SIG_ADDR1: dout_r <= SIG_BYTE1;
            SIG_ADDR2: dout_r <= SIG_BYTE2;
            default:   dout_r <= ERASED;
          endcase
        end
        default: dout_r <= ERASED;
      endcase
    end
  end

  assign link.dev_data_oe = ((mode == MODE_VERIFY) || (mode == MODE_SIG)) &&
                            !link.program_voltage_enable && !sweep_busy_r;
  assign link.dev_data_out = dout_r;

  assign busy                    = sweep_busy_r;
  assign code_table_read_block   = lock_level_one_bit_r;
  assign external_access_latched = access_latch_r;
  assign program_block           = lock_level_one_bit_r;
  assign verify_block            = lock_level_two_bit_r;
  assign ext_exec_block          = lock_level_three_bit_r;

endmodule // opv_device

//--- opv_link_sva.sv
`timescale 1ns/1ps
module opv_link_sva
  import opv_pkg::*;
(
  input logic              clk,
  input logic              rst,
  input logic [LO_W-1:0]   p1_addr_lo,
  input logic [HI_W-1:0]   p2_addr_hi,
  input logic [CTRL_W-1:0] ctrl,
  input logic              psen_n,
  input logic              program_pulse_strobe_n,
  input logic              program_voltage_enable,
  input logic [DATA_W-1:0] host_data_out,
  input logic              host_data_oe,
  input logic [DATA_W-1:0] dev_data_out,
  input logic              dev_data_oe
);
  wire  [21:0] ad = {p2_addr_hi, p1_addr_lo, host_data_out};
  wire         rd_mode = !psen_n && (ctrl == CTRL_VERIFY || ctrl == CTRL_SIG);
  logic [21:0] ad_q;
  logic [12:0] set_cnt;
  logic [12:0] hi_cnt;
  logic [4:0]  pcnt;
  logic        str_q;
  logic        vpp_q;

  // set_cnt and hi_cnt saturate, so long idle spans never wrap into a false hit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ad_q    <= '0;
      set_cnt <= '0;
      hi_cnt  <= '1;
      str_q   <= 1'b1;
      vpp_q   <= 1'b0;
      pcnt    <= '0;
    end else begin
      ad_q    <= ad;
      str_q   <= program_pulse_strobe_n;
      vpp_q   <= program_voltage_enable;
      set_cnt <= (ad != ad_q) ? 13'h0001 : set_cnt + {12'h000, ~&set_cnt};
      hi_cnt  <= !program_pulse_strobe_n ? '0 : hi_cnt + {12'h000, ~&hi_cnt};
      pcnt    <= (program_voltage_enable && !vpp_q) ? '0 :
                 pcnt + {4'h0, program_pulse_strobe_n && !str_q};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_rd_held;
    (rd_mode && $stable(ad) && $stable(ctrl)) [*4];
  endsequence
  sequence s_vpp_up;
    $rose(program_voltage_enable);
  endsequence

  chk_oe_read_modes: assert property (
    dev_data_oe |-> (ctrl == CTRL_VERIFY || ctrl == CTRL_SIG)
                    && !program_voltage_enable)
    else $error("device drives data outside read modes");
  chk_no_contention: assert property (
    !(dev_data_oe && host_data_oe))
    else $error("both ends drive data");
  chk_vpp_after_setup: assert property (
    s_vpp_up |-> host_data_oe && !psen_n && ctrl != CTRL_VERIFY
                 && ctrl != CTRL_SIG && set_cnt >= SETUP_CYC - 1)
    else $error("voltage raised before setup");
  chk_strobe_under_vpp: assert property (
    !program_pulse_strobe_n |-> program_voltage_enable)
    else $error("strobe low without voltage");
  chk_addr_setup: assert property (
    $fell(program_pulse_strobe_n) |-> set_cnt >= SETUP_CYC)
    else $error("address or data setup too short");
  chk_addr_hold: assert property (
    (ad != ad_q) |-> hi_cnt >= SETUP_CYC - 1)
    else $error("address or data hold too short");
  chk_strobe_gap: assert property (
    $fell(program_pulse_strobe_n) |-> hi_cnt >= GAP_CYC - 1)
    else $error("strobe high gap too short");
  chk_pulse_count: assert property (
    $fell(program_voltage_enable) |->
      pcnt == (ctrl == CTRL_PROG_CODE ? PULSES_CODE : PULSES_LONG))
    else $error("wrong strobe pulse count");
  chk_verify_steady: assert property (
    s_rd_held |-> $stable(dev_data_out))
    else $error("read data not settled");
endmodule // opv_link_sva

//--- tb_otp_program_verify_lock.sv
`timescale 1ns/1ps
module tb_otp_program_verify_lock;
  import opv_pkg::*;
  localparam int DEPTH = 64;
  // Arbitrary signature values
  localparam logic [DATA_W-1:0] SIG0 = 8'ha5;
  localparam logic [DATA_W-1:0] SIG1 = 8'h3c;
  localparam logic [DATA_W-1:0] SIG2 = 8'h0e;

  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              start = 1'b0;
  opv_mode_e         cmd_mode = MODE_VERIFY;
  logic [ADDR_W-1:0] cmd_addr = '0;
  logic [DATA_W-1:0] cmd_data = '0;
  logic              erase2 = 1'b0;
  logic              eas2 = 1'b0;
  logic              h_busy, h_done, d_busy, d2_busy, eal2;
  logic [DATA_W-1:0] rd_data;
  logic [3:0]        fl2;
  int                failures = 0;
  int                n_compared = 0;
  int                lvl = 0;
  int                code_m [DEPTH];
  int                enc_m [ENC_DEPTH];
  logic [CTRL_W-1:0] ctl [5] = '{CTRL_PROG_CODE, CTRL_PROG_ENC, CTRL_LOCK1,
                                 CTRL_LOCK2, CTRL_LOCK3};
  logic [ADDR_W-1:0] sig_a [4] = '{SIG_ADDR0, SIG_ADDR1, SIG_ADDR2, 14'h0061};
  logic [DATA_W-1:0] sig_e [4] = '{SIG0, SIG1, SIG2, 8'hff};
  int                st_k [10] = '{0, 0, 1, 0, 1, 4, 2, 0, 3, 4};
  int                st_n [10] = '{4, 5, 25, 5, 24, 25, 25, 5, 25, 25};
  int                st_x [10] = '{0, 0, 1, 1, 1, 0, 0, 0, 0, 0};

  opv_link_if lk ();
  opv_link_if lk2 ();

  always #12.5 clk = ~clk;

  opv_host i_opv_host (
    .clk(clk), .rst(rst), .link(lk.host), .start(start),
    .cmd_mode(cmd_mode), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .busy(h_busy), .done(h_done), .rd_data(rd_data));
  opv_device #(.CODE_DEPTH(DEPTH), .SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1),
    .SIG_BYTE2(SIG2)) i_opv_device (
    .clk(clk), .rst(rst), .link(lk.dev), .erase_req(1'b0),
    .external_access_select(1'b0), .busy(d_busy),
    .code_table_read_block(), .external_access_latched(),
    .program_block(), .verify_block(), .ext_exec_block());
  // Second pair: bench drives the link with short pulses to save run time
  opv_device #(.CODE_DEPTH(DEPTH), .SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1),
    .SIG_BYTE2(SIG2)) i_opv_device_2 (
    .clk(clk), .rst(rst), .link(lk2.dev), .erase_req(erase2),
    .external_access_select(eas2), .busy(d2_busy),
    .code_table_read_block(fl2[0]), .external_access_latched(eal2),
    .program_block(fl2[1]), .verify_block(fl2[2]), .ext_exec_block(fl2[3]));
  opv_link_sva i_opv_link_sva (
    .clk(clk), .rst(rst), .p1_addr_lo(lk.p1_addr_lo),
    .p2_addr_hi(lk.p2_addr_hi), .ctrl(lk.ctrl), .psen_n(lk.psen_n),
    .program_pulse_strobe_n(lk.program_pulse_strobe_n),
    .program_voltage_enable(lk.program_voltage_enable),
    .host_data_out(lk.host_data_out), .host_data_oe(lk.host_data_oe),
    .dev_data_out(lk.dev_data_out), .dev_data_oe(lk.dev_data_oe));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (failures == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic host_op(input opv_mode_e m, input int a, input int d);
    int k;
    @(negedge clk);
    start = 1'b1;
    cmd_mode = m;
    cmd_addr = a[ADDR_W-1:0];
    cmd_data = d[7:0];
    @(negedge clk);
    start = 1'b0;
    check(16'(h_busy), 16'h0001);
    for (k = 0; k < 30000 && h_done !== 1'b1; k++) @(negedge clk);
    check(16'(k < 30000), 16'h0001);
  endtask

  task automatic drv(input logic [4:0] c, input int a, input int d,
                     input int n);
    @(negedge clk);
    {lk2.p2_addr_hi, lk2.p1_addr_lo} = a[13:0];
    lk2.ctrl = c;
    lk2.host_data_out = d[7:0];
    lk2.host_data_oe = (n > 0);
    lk2.psen_n = 1'b0;
    repeat (3) @(negedge clk);
    if (n > 0) begin
      lk2.program_voltage_enable = 1'b1;
      repeat (2) @(negedge clk);
      repeat (n) begin
        lk2.program_pulse_strobe_n = 1'b0;
        repeat (2) @(negedge clk);
        lk2.program_pulse_strobe_n = 1'b1;
        repeat (2) @(negedge clk);
      end
      lk2.program_voltage_enable = 1'b0;
      @(negedge clk);
      lk2.host_data_oe = 1'b0;
    end
  endtask

  function automatic logic [7:0] vexp(input int a);
    if (lvl >= 2) return 8'hff;
    return 8'(~(code_m[a] ^ enc_m[a % ENC_DEPTH]));
  endfunction

  task automatic prog2(input int kind, input int a, input int d, input int n);
    drv(ctl[kind], a, d, n);
    if (n >= (kind == 0 ? PULSES_CODE : PULSES_LONG)) begin
      if (kind == 0 && lvl == 0) code_m[a] &= d;
      if (kind == 1 && lvl == 0) enc_m[a % ENC_DEPTH] &= d;
      if (kind > 1 && lvl == kind - 2) lvl = kind - 1;
    end
    @(negedge clk);
    check(16'(fl2), 16'({lvl == 3, lvl >= 2, lvl >= 1, lvl >= 1}));
  endtask

  task automatic rd2(input int a);
    drv(CTRL_VERIFY, a, 0, 0);
    check(16'(lk2.data), 16'(vexp(a)));
  endtask

  initial begin
    int a;
    int c;
    int k;
    lk2.p1_addr_lo = '0;
    lk2.p2_addr_hi = '0;
    lk2.ctrl = CTRL_VERIFY;
    lk2.rst_pin = 1'b1;
    lk2.psen_n = 1'b1;
    lk2.program_pulse_strobe_n = 1'b1;
    lk2.program_voltage_enable = 1'b0;
    lk2.host_data_out = '0;
    lk2.host_data_oe = 1'b0;
    foreach (code_m[i]) code_m[i] = 255;
    foreach (enc_m[i]) enc_m[i] = 255;
    k = $urandom(45941);
    repeat (12) @(negedge clk);
    rst = 1'b0;
    for (k = 0; k < 400 && (d_busy !== 1'b0 || d2_busy !== 1'b0); k++)
      @(negedge clk);
    check(16'({d_busy, d2_busy}), 16'h0000);
    a = $urandom % DEPTH;
    host_op(MODE_VERIFY, a, 0);
    check(16'(rd_data), 16'h00ff);
    check(16'({lk.p2_addr_hi, lk.p1_addr_lo}), 16'(a));
    for (k = 0; k < 4; k++) begin
      host_op(MODE_SIG, sig_a[k], 0);
      check(16'(rd_data), 16'(sig_e[k]));
    end
    c = $urandom % 255;
    host_op(MODE_PROG_CODE, a, c);
    host_op(MODE_VERIFY, a, 0);
    check(16'(rd_data), 16'(c));
    eas2 = 1'b1;
    repeat (3) @(negedge clk);
    check(16'(eal2), 16'h0001);
    for (k = 0; k < 10; k++) begin
      prog2(st_k[k], st_x[k] ? a ^ 1 : a, $urandom % 255, st_n[k]);
      rd2(a);
      rd2(a ^ 1);
    end
    drv(CTRL_SIG, SIG_ADDR1, 0, 0);
    check(16'(lk2.data), 16'(SIG1));
    erase2 = 1'b1;
    @(negedge clk);
    erase2 = 1'b0;
    @(negedge clk);
    check(16'(d2_busy), 16'h0001);
    for (k = 0; k < 400 && d2_busy !== 1'b0; k++) @(negedge clk);
    check(16'(d2_busy), 16'h0000);
    lvl = 0;
    foreach (code_m[i]) code_m[i] = 255;
    foreach (enc_m[i]) enc_m[i] = 255;
    check(16'(fl2), 16'h0000);
    rd2(a);
    summarize();
  end

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule // tb_otp_program_verify_lock
